// ==== pkg/ocb_regs.vh ====
// register indices, field positions, reset values and pattern codes for channel 13-16 control
`ifndef OCB_REGS_VH
`define OCB_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define OCB_IDX_GLOBAL_CTRL   8'h04
`define OCB_IDX_PATTERN       8'h3B
`define OCB_IDX_POWER_INVERT  8'h3C
`define OCB_IDX_CLK_DELAY     8'h43

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OCB_RST_GLOBAL_CTRL   16'h0000
`define OCB_RST_PATTERN       16'h0000
`define OCB_RST_POWER_INVERT  16'h0000
`define OCB_RST_CLK_DELAY     16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OCB_GC_PAT_EN_BIT     8
`define OCB_PAT15_HI          7
`define OCB_PAT15_LO          5
`define OCB_PAT16_HI          4
`define OCB_PAT16_LO          2
`define OCB_PD_DIG_HI         15
`define OCB_PD_DIG_LO         12
`define OCB_PD_LINE_HI        11
`define OCB_PD_LINE_LO        8
`define OCB_PD_ANA_HI         7
`define OCB_PD_ANA_LO         4
`define OCB_INV_HI            3
`define OCB_INV_LO            0
`define OCB_DLY_HI            4
`define OCB_DLY_LO            1

// ----------------------------------------------------------------
// delay step and test pattern codes
// ----------------------------------------------------------------
`define OCB_DELAY_STEP_PS     11'sd110
`define OCB_PAT_NORMAL        3'h0
`define OCB_PAT_ZEROS         3'h1
`define OCB_PAT_ONES          3'h2
`define OCB_PAT_TOGGLE        3'h3
`define OCB_PAT_RAMP          3'h4

`endif

// ==== design/ocb_clk_delay.v ====
// bit clock output delay code decoder: signed step count to picoseconds
`timescale 1ns/1ns
`include "ocb_regs.vh"

module ocb_clk_delay (
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire        [3:0]  code_i,
  output reg         [3:0]  code_o,
  output reg  signed [10:0] delay_ps_o
);

  // ----------------------------------------------------------------
  // two's complement code times the step size
  // ----------------------------------------------------------------
  wire signed [10:0] code_ext;
  wire signed [21:0] prod;

  assign code_ext = {{7{code_i[3]}}, code_i};
  assign prod     = code_ext * `OCB_DELAY_STEP_PS;

  // registered code and delay toward the analog delay cell
  always @(posedge clk_i) begin
    if (rst_i) begin
      code_o     <= 4'h0;
      delay_ps_o <= 11'sh000;
    end else begin
      code_o     <= code_i;
      delay_ps_o <= prod[10:0];
    end
  end

endmodule // ocb_clk_delay

// ==== design/ocb_top.v ====
// control registers and serial output path for channels 13 to 16
// ----------------------------------------------------------------
// Overview of operation
// - with per-output patterns on, bits 7-5 pick the pattern on output 15
// - with per-output patterns on, bits 4-2 pick the pattern on output 16
// - bits 15..12 power down digital block of channel 16..13
// - bits 11..8 power down serial output line 16..13
// - bits 7..4 power down analog block of channel 16..13
// - bits 3..0 invert output data on serial line 16..13
// - cleared power-down or invert bits mean normal operation, the reset state
// - bit clock delay field at bits 4-1, 110 ps per step
// - delay field is signed two's complement step count
// - positive delay adds setup and removes hold, negative the reverse
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "ocb_regs.vh"

module ocb_top #(
  parameter DATA_W = 14
) (
  input  wire               clk_i,
  input  wire               rst_i,
  // wishbone classic slave
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  input  wire               wb_we_i,
  input  wire        [9:0]  wb_adr_i,
  input  wire        [3:0]  wb_sel_i,
  input  wire        [31:0] wb_dat_i,
  output reg         [31:0] wb_dat_o,
  output reg                wb_ack_o,
  // sample words per channel, same clock
  input  wire [DATA_W-1:0]  ch13_data_i,
  input  wire [DATA_W-1:0]  ch14_data_i,
  input  wire [DATA_W-1:0]  ch15_data_i,
  input  wire [DATA_W-1:0]  ch16_data_i,
  // bit clock from the serializer clock source
  input  wire               serial_bit_clock_i,
  // serial link side
  output reg                serial_bit_clock_o,
  output reg         [3:0]  serial_data_o,
  output reg                word_start_o,
  // power and delay controls toward the front-end
  output reg         [3:0]  digital_powerdown_o,
  output reg         [3:0]  line_powerdown_o,
  output reg         [3:0]  analog_powerdown_o,
  output wire        [3:0]  bit_clock_delay_code_o,
  output wire signed [10:0] bit_clock_delay_ps_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // byte-lane merge of a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  sel;
    begin
      lane_merge[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
      lane_merge[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  // test pattern or live data for one line
  function [DATA_W-1:0] pattern_word;
    input [2:0]        code;
    input [DATA_W-1:0] live;
    input              toggle;
    input [DATA_W-1:0] ramp;
    begin
      case (code)
        `OCB_PAT_ZEROS:  pattern_word = {DATA_W{1'b0}};
        `OCB_PAT_ONES:   pattern_word = {DATA_W{1'b1}};
        `OCB_PAT_TOGGLE: pattern_word = toggle ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
        `OCB_PAT_RAMP:   pattern_word = ramp;
        default:         pattern_word = live;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [15:0] global_ctrl_r;
  reg  [15:0] test_pattern_outputs_15_16_r;
  reg  [15:0] channel_power_and_invert_r;
  reg  [15:0] bit_clock_output_delay_r;

  wire [7:0]  reg_index;
  wire        bus_req;
  wire        bus_wr;
  wire [15:0] wr_val;
  wire [1:0]  wr_sel;

  assign reg_index = wb_adr_i[9:2];
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr    = bus_req & wb_we_i;
  assign wr_val    = wb_dat_i[15:0];
  assign wr_sel    = wb_sel_i[1:0];

  // ----------------------------------------------------------------
  // wishbone write path
  // ----------------------------------------------------------------

  // all registers reset to zero, writes honour byte lanes
  always @(posedge clk_i) begin
    if (rst_i) begin
      global_ctrl_r                <= `OCB_RST_GLOBAL_CTRL;
      test_pattern_outputs_15_16_r <= `OCB_RST_PATTERN;
      channel_power_and_invert_r   <= `OCB_RST_POWER_INVERT;
      bit_clock_output_delay_r     <= `OCB_RST_CLK_DELAY;
    end else if (bus_wr) begin
      case (reg_index)
        `OCB_IDX_GLOBAL_CTRL:
          global_ctrl_r <= lane_merge(global_ctrl_r, wr_val, wr_sel);
        `OCB_IDX_PATTERN:
          test_pattern_outputs_15_16_r <=
            lane_merge(test_pattern_outputs_15_16_r, wr_val, wr_sel);
        `OCB_IDX_POWER_INVERT:
          channel_power_and_invert_r <=
            lane_merge(channel_power_and_invert_r, wr_val, wr_sel);
        `OCB_IDX_CLK_DELAY:
          bit_clock_output_delay_r <=
            lane_merge(bit_clock_output_delay_r, wr_val, wr_sel);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wishbone read path and acknowledge
  // ----------------------------------------------------------------

  // one wait state; unmapped indices answer with zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (reg_index)
          `OCB_IDX_GLOBAL_CTRL:  wb_dat_o <= {16'h0000, global_ctrl_r};
          `OCB_IDX_PATTERN:      wb_dat_o <= {16'h0000, test_pattern_outputs_15_16_r};
          `OCB_IDX_POWER_INVERT: wb_dat_o <= {16'h0000, channel_power_and_invert_r};
          `OCB_IDX_CLK_DELAY:    wb_dat_o <= {16'h0000, bit_clock_output_delay_r};
          default:               wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire       per_output_pattern_enable;
  wire [2:0] pattern_code_out15;
  wire [2:0] pattern_code_out16;
  wire [3:0] pd_dig;
  wire [3:0] pd_line;
  wire [3:0] pd_ana;
  wire [3:0] output_invert;
  wire [3:0] delay_field;
  wire [2:0] pat15_eff;
  wire [2:0] pat16_eff;

  assign per_output_pattern_enable = global_ctrl_r[`OCB_GC_PAT_EN_BIT];
  assign pattern_code_out15 = test_pattern_outputs_15_16_r[`OCB_PAT15_HI:`OCB_PAT15_LO];
  assign pattern_code_out16 = test_pattern_outputs_15_16_r[`OCB_PAT16_HI:`OCB_PAT16_LO];
  assign pd_dig        = channel_power_and_invert_r[`OCB_PD_DIG_HI:`OCB_PD_DIG_LO];
  assign pd_line       = channel_power_and_invert_r[`OCB_PD_LINE_HI:`OCB_PD_LINE_LO];
  assign pd_ana        = channel_power_and_invert_r[`OCB_PD_ANA_HI:`OCB_PD_ANA_LO];
  assign output_invert = channel_power_and_invert_r[`OCB_INV_HI:`OCB_INV_LO];
  assign delay_field   = bit_clock_output_delay_r[`OCB_DLY_HI:`OCB_DLY_LO];

  // pattern fields count only while per-output selection is on
  assign pat15_eff = per_output_pattern_enable ? pattern_code_out15 : `OCB_PAT_NORMAL;
  assign pat16_eff = per_output_pattern_enable ? pattern_code_out16 : `OCB_PAT_NORMAL;

  // ----------------------------------------------------------------
  // power-down outputs, index 0 is channel or line 13
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      digital_powerdown_o <= 4'h0;
      line_powerdown_o    <= 4'h0;
      analog_powerdown_o  <= 4'h0;
    end else begin
      digital_powerdown_o <= pd_dig;
      line_powerdown_o    <= pd_line;
      analog_powerdown_o  <= pd_ana;
    end
  end

  // ----------------------------------------------------------------
  // bit clock delay decode
  // ----------------------------------------------------------------
  ocb_clk_delay u_clk_delay (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .code_i     (delay_field),
    .code_o     (bit_clock_delay_code_o),
    .delay_ps_o (bit_clock_delay_ps_o)
  );

  // ----------------------------------------------------------------
  // bit clock synchroniser and edge detect
  // ----------------------------------------------------------------
  reg  bclk_meta_r;
  reg  bclk_sync_r;
  reg  bclk_prev_r;
  wire bclk_rise;

  // meta stage feeds only the sync stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      bclk_meta_r <= 1'b0;
      bclk_sync_r <= 1'b0;
      bclk_prev_r <= 1'b0;
    end else begin
      bclk_meta_r <= serial_bit_clock_i;
      bclk_sync_r <= bclk_meta_r;
      bclk_prev_r <= bclk_sync_r;
    end
  end

  assign bclk_rise = bclk_sync_r & ~bclk_prev_r;

  // regenerated bit clock, aligned with the data flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_bit_clock_o <= 1'b0;
    end else begin
      serial_bit_clock_o <= bclk_sync_r;
    end
  end

  // ----------------------------------------------------------------
  // word build per line
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] ramp_r;
  reg               toggle_r;
  reg  [DATA_W-1:0] word_src [0:3];
  reg  [DATA_W-1:0] word_new [0:3];
  integer           k;

  // digital power-down blanks the word, invert flips it
  always @* begin
    word_src[0] = ch13_data_i;
    word_src[1] = ch14_data_i;
    word_src[2] = pattern_word(pat15_eff, ch15_data_i, toggle_r, ramp_r);
    word_src[3] = pattern_word(pat16_eff, ch16_data_i, toggle_r, ramp_r);
    for (k = 0; k < 4; k = k + 1) begin
      if (pd_dig[k])
        word_new[k] = {DATA_W{1'b0}};
      else if (output_invert[k])
        word_new[k] = ~word_src[k];
      else
        word_new[k] = word_src[k];
    end
  end

  // ----------------------------------------------------------------
  // serial shift engine, MSB first, one bit per bit clock rise
  // ----------------------------------------------------------------
  reg  [4:0]        bit_cnt_r;
  reg  [DATA_W-1:0] shift_r [0:3];
  localparam [4:0]  LAST_BIT = DATA_W[4:0] - 5'h01;  // index of the last bit of a word
  wire              word_wrap;
  integer           n;

  assign word_wrap = (bit_cnt_r == LAST_BIT);

  // first rise after reset loads a fresh word
  always @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_r    <= LAST_BIT;
      ramp_r       <= {DATA_W{1'b0}};
      toggle_r     <= 1'b0;
      word_start_o <= 1'b0;
    end else if (bclk_rise) begin
      word_start_o <= word_wrap;
      if (word_wrap) begin
        bit_cnt_r <= 5'h00;
        ramp_r    <= ramp_r + 1'b1;
        toggle_r  <= ~toggle_r;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // shifters and line outputs; a powered-down line sits low
  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_data_o <= 4'h0;
      for (n = 0; n < 4; n = n + 1) begin
        shift_r[n] <= {DATA_W{1'b0}};
      end
    end else if (bclk_rise) begin
      for (n = 0; n < 4; n = n + 1) begin
        shift_r[n] <= word_wrap ? {word_new[n][DATA_W-2:0], 1'b0}
                                : {shift_r[n][DATA_W-2:0], 1'b0};
        serial_data_o[n] <= pd_line[n] ? 1'b0 :
                            (word_wrap ? word_new[n][DATA_W-1] : shift_r[n][DATA_W-1]);
      end
    end
  end

endmodule // ocb_top

// ==== tb/ocb_top_chk.sv ====
// checker for the channel 13-16 control block ports
`timescale 1ns/1ns
`include "ocb_regs.vh"
module ocb_top_chk (
  input wire               clk_i,
  input wire               rst_i,
  input wire               wb_cyc_i,
  input wire               wb_stb_i,
  input wire               wb_we_i,
  input wire        [9:0]  wb_adr_i,
  input wire        [3:0]  wb_sel_i,
  input wire        [31:0] wb_dat_i,
  input wire        [31:0] wb_dat_o,
  input wire               wb_ack_o,
  input wire        [3:0]  digital_powerdown_o,
  input wire        [3:0]  line_powerdown_o,
  input wire        [3:0]  analog_powerdown_o,
  input wire        [3:0]  bit_clock_delay_code_o,
  input wire signed [10:0] bit_clock_delay_ps_o
);
  // ----------------------------------------------------------------
  // shadow copies of the power and delay registers
  // ----------------------------------------------------------------
  wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  reg  [15:0] pi_r;
  reg  [15:0] dl_r;
  function [15:0] mg(input [15:0] o);
    mg = {wb_sel_i[1] ? wb_dat_i[15:8] : o[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : o[7:0]};
  endfunction
  // byte-lane merge on each taken write
  always @(posedge clk_i) begin
    if (rst_i) begin
      pi_r <= 16'h0000;
      dl_r <= 16'h0000;
    end else if (wr) begin
      if (wb_adr_i[9:2] == `OCB_IDX_POWER_INVERT) pi_r <= mg(pi_r);
      if (wb_adr_i[9:2] == `OCB_IDX_CLK_DELAY) dl_r <= mg(dl_r);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // bus handshake and control outputs
  // ----------------------------------------------------------------
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_dig_pd: assert property (!wr && !$past(wr) |-> digital_powerdown_o == pi_r[15:12])
    else $error("digital power-down mismatch");
  chk_line_pd: assert property (!wr && !$past(wr) |-> line_powerdown_o == pi_r[11:8])
    else $error("line power-down mismatch");
  chk_ana_pd: assert property (!wr && !$past(wr) |-> analog_powerdown_o == pi_r[7:4])
    else $error("analog power-down mismatch");
  chk_dly_code: assert property (!wr && !$past(wr) |-> bit_clock_delay_code_o == dl_r[4:1])
    else $error("delay code mismatch");
  chk_dly_ps: assert property (!wr && !$past(wr) |->
    bit_clock_delay_ps_o == $signed(dl_r[4:1]) * `OCB_DELAY_STEP_PS)
    else $error("delay in ps mismatch");
endmodule // ocb_top_chk
bind ocb_top ocb_top_chk u_chk (.*);

// ==== tb/ocb_rx_model.sv ====
// capture receiver model: deserialises the four serial lines
`timescale 1ns/1ns
module ocb_rx_model #(
  parameter DATA_W = 14
) (
  input  wire                  bclk_i,
  input  wire [3:0]            sd_i,
  input  wire                  ws_i,
  output reg  [4*DATA_W-1:0]   word_o,
  output reg                   tgl_o
);
  reg [4*DATA_W-1:0] sh;
  integer            n;
  integer            l;
  initial begin
    word_o = '0;
    tgl_o = 1'b0;
    sh = '0;
    n = -1;
  end
  // sample mid-bit on the falling bit clock, msb first, resync on word start
  always @(negedge bclk_i) begin
    if (ws_i === 1'b1) n = 0;
    if (n >= 0) begin
      for (l = 0; l < 4; l = l + 1) sh[l*DATA_W +: DATA_W] = {sh[l*DATA_W +: DATA_W-1], sd_i[l]};
      n = n + 1;
      if (n == DATA_W) begin
        word_o <= sh;
        tgl_o <= ~tgl_o;
        n = -1;
      end
    end
  end
endmodule // ocb_rx_model

// ==== tb/ocb_top_tb.sv ====
// self-checking bench for the channel 13-16 control block
`timescale 1ns/1ns
`include "ocb_regs.vh"
module ocb_top_tb;
  localparam DW = 14;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serial_bit_clock_i;
  logic serial_bit_clock_o, word_start_o, rx_tgl;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i, serial_data_o, digital_powerdown_o, line_powerdown_o;
  logic [3:0] analog_powerdown_o, bit_clock_delay_code_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic signed [10:0] bit_clock_delay_ps_o;
  logic [DW-1:0] ch13_data_i, ch14_data_i, ch15_data_i, ch16_data_i;
  logic [4*DW-1:0] rx_word, p;
  logic [63:0] rdq[$], wq[$];
  integer seed, error_cnt, tests_run, cyc_cnt, i, c;
  logic [15:0] v;
  ocb_top #(.DATA_W(DW)) dut (.*);
  ocb_rx_model #(.DATA_W(DW)) u_rx (.bclk_i(serial_bit_clock_o), .sd_i(serial_data_o),
    .ws_i(word_start_o), .word_o(rx_word), .tgl_o(rx_tgl));
  // clocks and hang guard
  always #5 clk_i = ~clk_i;
  always #40 serial_bit_clock_i = ~serial_bit_clock_i;
  always @(posedge clk_i) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task cmp(input string nm, input [63:0] e, input [63:0] s);
    tests_run = tests_run + 1;
    if (e !== s) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // watchers take the oldest note when a result appears
  always @(posedge clk_i) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rdq.size() > 0)
    cmp("read data", rdq.pop_front(), wb_dat_o);
  always @(rx_tgl) if (wq.size() > 0) cmp("serial word", wq.pop_front(), rx_word);
  // ----------------------------------------------------------------
  // wishbone classic master and helpers
  // ----------------------------------------------------------------
  task bus(input w, input [7:0] ix, input [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {ix, 2'h0};
    wb_dat_i <= {16'($random(seed)), d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input [7:0] ix, input [15:0] e);
    rdq.push_back({48'h0, e});
    bus(1'b0, ix, 16'h0000);
  endtask
  function [63:0] ew(input [15:0] pi, input pe, input [15:0] pt);
    logic [DW-1:0] w;
    logic [2:0] k;
    integer l;
    ew = '0;
    for (l = 0; l < 4; l = l + 1) begin
      w = (l == 0) ? ch13_data_i : (l == 1) ? ch14_data_i : (l == 2) ? ch15_data_i : ch16_data_i;
      k = (l == 2) ? pt[7:5] : pt[4:2];
      if (pe && l > 1 && k == `OCB_PAT_ZEROS) w = '0;
      if (pe && l > 1 && k == `OCB_PAT_ONES) w = '1;
      if (pi[12+l]) w = '0;
      else if (pi[l]) w = ~w;
      if (pi[8+l]) w = '0;
      ew[l*DW +: DW] = w;
    end
  endfunction
  // skip words in flight, then note the next one
  task word_chk(input [63:0] e);
    repeat (2) @(rx_tgl);
    #1 wq.push_back(e);
    @(rx_tgl);
    @(posedge clk_i);
  endtask
  task give_verdict;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk_i, serial_bit_clock_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {ch13_data_i, ch14_data_i, ch15_data_i, ch16_data_i} = '0;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    seed = 32'he6eb;
    {error_cnt, tests_run, cyc_cnt} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OCB_IDX_GLOBAL_CTRL, 16'h0000);
    rd(`OCB_IDX_PATTERN, 16'h0000);
    rd(`OCB_IDX_POWER_INVERT, 16'h0000);
    rd(`OCB_IDX_CLK_DELAY, 16'h0000);
    rd(8'h50, 16'h0000);
    $display("test reset and readback done");
    for (i = 0; i < 3; i = i + 1) begin
      v = $random(seed);
      bus(1'b1, `OCB_IDX_POWER_INVERT, v);
      rd(`OCB_IDX_POWER_INVERT, v);
      bus(1'b1, `OCB_IDX_PATTERN, v & 16'h00FC);
      rd(`OCB_IDX_PATTERN, v & 16'h00FC);
    end
    for (c = 0; c < 16; c = c + 1) begin
      bus(1'b1, `OCB_IDX_CLK_DELAY, 16'(c << 1));
      repeat (2) @(posedge clk_i);
      cmp("delay ps", 11'($signed(c[3:0]) * 110), bit_clock_delay_ps_o);
      cmp("delay code", c[3:0], bit_clock_delay_code_o);
    end
    rd(`OCB_IDX_CLK_DELAY, 16'h001E);
    $display("test delay codes done");
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_i);
      {ch13_data_i, ch14_data_i, ch15_data_i, ch16_data_i} <= {$random(seed), $random(seed)};
      v = (i == 0) ? 16'h0000 : $random(seed);
      bus(1'b1, `OCB_IDX_POWER_INVERT, v);
      word_chk(ew(v, 1'b0, 16'h0000));
    end
    $display("test power-down and invert done");
    bus(1'b1, `OCB_IDX_POWER_INVERT, 16'h0000);
    bus(1'b1, `OCB_IDX_GLOBAL_CTRL, 16'h0100);
    for (i = 0; i < 3; i = i + 1) begin
      v = (i == 0) ? 16'h0028 : (i == 1) ? 16'h0044 : 16'h0014;
      bus(1'b1, `OCB_IDX_PATTERN, v);
      word_chk(ew(16'h0000, 1'b1, v));
    end
    // alternating pattern on output 15, ramp on output 16: next word follows the last one
    bus(1'b1, `OCB_IDX_PATTERN, 16'h0070);
    repeat (2) @(rx_tgl);
    #1 p = rx_word;
    cmp("toggle level", 1'b1, p[2*DW +: DW] == '0 || p[2*DW +: DW] == '1);
    wq.push_back({8'h00, p[3*DW +: DW] + 1'b1, ~p[2*DW +: DW], ch14_data_i, ch13_data_i});
    @(rx_tgl);
    @(posedge clk_i);
    // codes that would force zeros and ones must have no effect once selection is off
    v = 16'h0028;
    bus(1'b1, `OCB_IDX_PATTERN, v);
    bus(1'b1, `OCB_IDX_GLOBAL_CTRL, 16'h0000);
    word_chk(ew(16'h0000, 1'b0, v));
    $display("test pattern selection done");
    give_verdict;
  end
endmodule // ocb_top_tb
